// file: design/eeprom_pkg.sv
// shared constants and types for the two-wire eeprom slave front end
package eeprom_pkg;

	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int NS_PER_MS = 1000000;
	// longest time rounds down to whole cycles
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int TIMER_W = 20;

	// ==========================================
	// control byte and bit framing
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam logic [3:0] LAST_DATA_CNT = 4'h7;
	localparam logic [3:0] ACK_CNT = 4'h8;
	localparam logic [3:0] DONE_CNT = 4'h9;
	localparam logic [3:0] BIT_TOP = 4'h7;
	localparam logic SDA_LOW = 1'b0;

	// ==========================================
	// storage
	localparam int PAGE_DEPTH = 16;
	localparam int IDX_W = 4;
	localparam int FIFO_DEPTH = 32;
	localparam int PROTECT_BIT = 7;
	localparam logic [15:0] NO_VALID = 16'h0000;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [3:0] IDX_STEP = 4'h1;
	localparam logic [3:0] IDX_LAST = 4'hf;
	localparam logic [3:0] CNT_STEP = 4'h1;
	localparam logic [19:0] TIMER_STEP = 20'h0_0001;
	localparam logic [19:0] TIMER_ZERO = 20'h0_0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTRL = 3'b001,
		ST_WADDR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RSTART = 3'b100,
		ST_READ = 3'b101,
		ST_IGNORE = 3'b110
	} link_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} mem_write_t;

	typedef struct packed {
		logic cascadable;
		logic [2:0] chip_select;
	} strap_t;

endpackage

// file: design/bus_condition.sv
// pin synchroniser and start, stop and clock edge detector
`timescale 1ns/1ps
module bus_condition (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [3:0] strap_pins_i,
	output logic scl_o,
	output logic sda_o,
	output logic scl_rise_o,
	output logic scl_fall_o,
	output logic start_o,
	output logic stop_o,
	output logic [3:0] strap_o
);
	logic [5:0] meta;
	logic [5:0] stable;
	logic prev_scl;
	logic prev_sda;

	// ==========================================
	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			meta <= 6'h3f;
			stable <= 6'h3f;
			prev_scl <= 1'b1;
			prev_sda <= 1'b1;
		end else begin
			meta <= {strap_pins_i, scl_i, sda_i};
			stable <= meta;
			prev_scl <= stable[1];
			prev_sda <= stable[0];
		end
	end

	assign scl_o = stable[1];
	assign sda_o = stable[0];
	assign strap_o = stable[5:2];
	assign scl_rise_o = stable[1] && !prev_scl;
	assign scl_fall_o = !stable[1] && prev_scl;
	// clock must be high in both samples so a clock edge is never taken for a condition
	assign start_o = stable[1] && prev_scl && prev_sda && !stable[0];
	assign stop_o = stable[1] && prev_scl && !prev_sda && stable[0];
endmodule // bus_condition

// file: design/word_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_idx;
	logic [PTR_W-1:0] rd_idx;
	logic [PTR_W:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = count != CNT_FULL;
	assign out_valid_o = count != '0;
	assign out_data_o = store[rd_idx];

	always_ff @(posedge clock_i) begin
		if (push) begin
			store[wr_idx] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == PTR_W'(DEPTH - 1)) ? '0 : wr_idx + PTR_ONE;
			end
			if (pop) begin
				rd_idx <= (rd_idx == PTR_W'(DEPTH - 1)) ? '0 : rd_idx + PTR_ONE;
			end
			count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
endmodule // word_fifo

// file: design/eeprom_slave.sv
// two-wire eeprom slave: conditions, bit engine, control decode, byte and page write
// How it works
// - data changes only while clock low
// - falling data with clock high starts
// - rising data with clock high stops
// - one bit per clock, sampled high
// - page buffer keeps only last sixteen bytes
// - receiver acknowledges on ninth clock pulse
// - acknowledge held low through clock high
// - no acknowledge during internal write cycle
// - master not-acknowledge releases data line
// - control byte acknowledged only for 1010
// - cascadable: chip select equals address pins
// - non-cascadable: chip select bits ignored
// - low control bit picks read or write
// - sequential read wraps inside this device
// - byte after write control loads pointer
// - data byte acked, stop starts write
// - write cycle ends within five milliseconds
// - writes to upper half are dropped
`timescale 1ns/1ps
module eeprom_slave #(
	parameter int unsigned WRITE_CYCLE_CLOCKS = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic chip_select_pin_bit0_i,
	input wire logic chip_select_pin_bit1_i,
	input wire logic chip_select_pin_bit2_i,
	input wire logic cascadable_i,
	output logic [7:0] rd_addr_o,
	input wire logic [7:0] rd_data_i,
	output logic mem_wr_valid_o,
	input wire logic mem_wr_ready_i,
	output eeprom_pkg::mem_write_t mem_wr_o,
	output logic busy_o
);
	// ==========================================
	// line conditions
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	eeprom_pkg::strap_t straps;

	bus_condition u_cond (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.strap_pins_i({cascadable_i, chip_select_pin_bit2_i,
			chip_select_pin_bit1_i, chip_select_pin_bit0_i}),
		.scl_o(scl_q),
		.sda_o(sda_q),
		.scl_rise_o(scl_rise),
		.scl_fall_o(scl_fall),
		.start_o(start_seen),
		.stop_o(stop_seen),
		.strap_o(straps)
	);

	// ==========================================
	// state
	eeprom_pkg::link_state_t state;
	eeprom_pkg::link_state_t next_state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [7:0] ptr;
	logic sda_oe;
	logic master_ack;
	logic [7:0] page_data [eeprom_pkg::PAGE_DEPTH];
	logic [15:0] page_valid;
	logic pushing;
	logic [3:0] push_idx;
	logic [19:0] timer;
	logic busy;

	// ==========================================
	// decode
	wire ack_fall = scl_fall && bit_cnt == eeprom_pkg::ACK_CNT;
	wire done_fall = scl_fall && bit_cnt == eeprom_pkg::DONE_CNT;
	wire rx_rise = scl_rise && bit_cnt < eeprom_pkg::ACK_CNT;
	wire type_ok = shift[7:4] == eeprom_pkg::TYPE_CODE;
	// only the cascadable variant compares the pins
	wire cs_ok = !straps.cascadable || shift[3:1] == straps.chip_select;
	wire ctrl_hit = type_ok && cs_ok && !busy;
	wire is_write_rx = state == eeprom_pkg::ST_WADDR || state == eeprom_pkg::ST_WDATA;
	wire want_ack = (state == eeprom_pkg::ST_CTRL && ctrl_hit) || (is_write_rx && !busy);
	wire load_read = done_fall && (state == eeprom_pkg::ST_RSTART
		|| (state == eeprom_pkg::ST_READ && master_ack));
	wire tx_fall = scl_fall && state == eeprom_pkg::ST_READ
		&& bit_cnt != 4'h0 && bit_cnt < eeprom_pkg::ACK_CNT;
	wire tx_bit = tx[3'(eeprom_pkg::BIT_TOP - bit_cnt)];
	wire commit = stop_seen && state == eeprom_pkg::ST_WDATA && page_valid != eeprom_pkg::NO_VALID;
	wire [7:0] push_addr = {ptr[7:4], push_idx};
	wire push_ok = pushing && page_valid[push_idx] && !push_addr[eeprom_pkg::PROTECT_BIT];
	wire fifo_in_ready;
	wire push_advance = pushing && (!push_ok || fifo_in_ready);

	assign busy = pushing || timer != eeprom_pkg::TIMER_ZERO;

	always_comb begin
		next_state = state;
		unique case (state)
			eeprom_pkg::ST_CTRL: begin
				if (!ctrl_hit) begin
					next_state = eeprom_pkg::ST_IGNORE;
				end else if (shift[0]) begin
					next_state = eeprom_pkg::ST_RSTART;
				end else begin
					next_state = eeprom_pkg::ST_WADDR;
				end
			end
			eeprom_pkg::ST_WADDR: next_state = eeprom_pkg::ST_WDATA;
			eeprom_pkg::ST_WDATA: next_state = eeprom_pkg::ST_WDATA;
			eeprom_pkg::ST_IDLE,
			eeprom_pkg::ST_RSTART,
			eeprom_pkg::ST_READ,
			eeprom_pkg::ST_IGNORE: next_state = state;
			default: next_state = eeprom_pkg::ST_IDLE;
		endcase
	end

	// ==========================================
	// framing: a command is only taken after a start
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state <= eeprom_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
		end else if (start_seen) begin
			state <= eeprom_pkg::ST_CTRL;
			bit_cnt <= 4'h0;
		end else if (stop_seen) begin
			state <= eeprom_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
		end else if (scl_rise && bit_cnt < eeprom_pkg::DONE_CNT) begin
			bit_cnt <= bit_cnt + eeprom_pkg::CNT_STEP;
		end else if (ack_fall) begin
			state <= next_state;
		end else if (done_fall) begin
			bit_cnt <= 4'h0;
			if (state == eeprom_pkg::ST_RSTART || load_read) begin
				state <= eeprom_pkg::ST_READ;
			end else if (state == eeprom_pkg::ST_READ) begin
				state <= eeprom_pkg::ST_IGNORE;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			shift <= 8'h00;
			master_ack <= 1'b0;
		end else if (rx_rise) begin
			shift <= {shift[6:0], sda_q};
		end else if (scl_rise && bit_cnt == eeprom_pkg::ACK_CNT) begin
			master_ack <= sda_q == eeprom_pkg::SDA_LOW;
		end
	end

	// ==========================================
	// data line driver, changed just after a clock fall and cleared at a start or stop
	always_ff @(posedge clock_i) begin
		if (!resetn_i || start_seen || stop_seen) begin
			sda_oe <= 1'b0;
			tx <= 8'h00;
		end else if (ack_fall) begin
			sda_oe <= want_ack;
		end else if (load_read) begin
			tx <= rd_data_i;
			sda_oe <= !rd_data_i[7];
		end else if (done_fall) begin
			sda_oe <= 1'b0;
		end else if (tx_fall) begin
			sda_oe <= !tx_bit;
		end
	end

	// ==========================================
	// address pointer and page buffer
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ptr <= 8'h00;
		end else if (ack_fall && state == eeprom_pkg::ST_WADDR && !busy) begin
			ptr <= shift;
		end else if (ack_fall && state == eeprom_pkg::ST_WDATA && !busy) begin
			ptr <= {ptr[7:4], ptr[3:0] + eeprom_pkg::IDX_STEP};
		end else if (scl_rise && bit_cnt == eeprom_pkg::LAST_DATA_CNT
			&& state == eeprom_pkg::ST_READ) begin
			// wraps at the top of this device, never into a neighbour
			ptr <= ptr + eeprom_pkg::PTR_STEP;
		end
	end

	always_ff @(posedge clock_i) begin
		if (ack_fall && state == eeprom_pkg::ST_WDATA && !busy) begin
			page_data[ptr[3:0]] <= shift;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			page_valid <= eeprom_pkg::NO_VALID;
		end else if (ack_fall && state == eeprom_pkg::ST_WADDR && !busy) begin
			page_valid <= eeprom_pkg::NO_VALID;
		end else if (ack_fall && state == eeprom_pkg::ST_WDATA && !busy) begin
			page_valid[ptr[3:0]] <= 1'b1;
		end
	end

	// ==========================================
	// internal write cycle: drain the page while the timed programming counts down
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pushing <= 1'b0;
			push_idx <= 4'h0;
		end else if (commit) begin
			pushing <= 1'b1;
			push_idx <= 4'h0;
		end else if (push_advance) begin
			push_idx <= push_idx + eeprom_pkg::IDX_STEP;
			pushing <= push_idx != eeprom_pkg::IDX_LAST;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			timer <= eeprom_pkg::TIMER_ZERO;
		end else if (commit) begin
			timer <= eeprom_pkg::TIMER_W'(WRITE_CYCLE_CLOCKS);
		end else if (timer != eeprom_pkg::TIMER_ZERO) begin
			timer <= timer - eeprom_pkg::TIMER_STEP;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= busy || commit;
		end
	end

	// the fifo lets the array side stall; a full fifo holds the drain
	eeprom_pkg::mem_write_t push_word;
	assign push_word = '{addr: push_addr, data: page_data[push_idx]};

	word_fifo #(
		.WIDTH($bits(eeprom_pkg::mem_write_t)),
		.DEPTH(eeprom_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.in_valid_i(push_ok),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_word),
		.out_valid_o(mem_wr_valid_o),
		.out_ready_i(mem_wr_ready_i),
		.out_data_o(mem_wr_o)
	);

	assign sda_o = eeprom_pkg::SDA_LOW;
	assign sda_oe_o = sda_oe;
	assign rd_addr_o = ptr;

	// ==========================================
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_ctrl_byte_end;
		ack_fall && state == eeprom_pkg::ST_CTRL;
	endsequence

	sequence s_write_data_stop;
		stop_seen && state == eeprom_pkg::ST_WDATA && page_valid != eeprom_pkg::NO_VALID;
	endsequence

	chk_start_restart: assert property (start_seen |=>
		state == eeprom_pkg::ST_CTRL && bit_cnt == 4'h0 && !sda_oe && !$rose(pushing))
		else $error("start did not restart control byte reception");

	chk_stop_release: assert property (stop_seen |=>
		!sda_oe && state == eeprom_pkg::ST_IDLE)
		else $error("stop did not release the bus");

	chk_busy_no_ack: assert property (ack_fall && busy |=> !sda_oe)
		else $error("acknowledge driven during write cycle");

	chk_type_code: assert property (s_ctrl_byte_end ##0 !type_ok |=>
		!sda_oe && state == eeprom_pkg::ST_IGNORE)
		else $error("wrong type code was acknowledged");

	chk_chip_select: assert property (s_ctrl_byte_end ##0 straps.cascadable
		&& shift[3:1] != straps.chip_select |=> state == eeprom_pkg::ST_IGNORE)
		else $error("chip select mismatch was accepted");

	chk_rw_select: assert property (s_ctrl_byte_end ##0 ctrl_hit |=> sda_oe
		&& state == ($past(shift[0]) ? eeprom_pkg::ST_RSTART : eeprom_pkg::ST_WADDR))
		else $error("read or write not selected from control byte");

	chk_ack_stable: assert property (sda_oe && bit_cnt == eeprom_pkg::DONE_CNT
		&& !scl_fall && !start_seen && !stop_seen |=> sda_oe)
		else $error("acknowledge released during clock high");

	chk_nack_release: assert property (done_fall && state == eeprom_pkg::ST_READ
		&& !master_ack |=> !sda_oe && state == eeprom_pkg::ST_IGNORE)
		else $error("line not released after master not-acknowledge");

	chk_ptr_load: assert property (ack_fall && state == eeprom_pkg::ST_WADDR && !busy
		|=> ptr == $past(shift))
		else $error("word address not loaded into pointer");

	chk_write_start: assert property (s_write_data_stop |=> pushing && busy_o
		&& timer == eeprom_pkg::TIMER_W'(WRITE_CYCLE_CLOCKS))
		else $error("stop after data did not start write cycle");

	chk_read_wrap: assert property (scl_rise && bit_cnt == eeprom_pkg::LAST_DATA_CNT
		&& state == eeprom_pkg::ST_READ |=> ptr == $past(ptr) + eeprom_pkg::PTR_STEP)
		else $error("read pointer did not advance");

	// watches the array port itself, so a fault anywhere on the drain path shows
	chk_protect: assert property (mem_wr_valid_o
		|-> !mem_wr_o.addr[eeprom_pkg::PROTECT_BIT])
		else $error("write into protected half");

endmodule // eeprom_slave

// file: test/i2c_bus_master.sv
// two-wire bus master model: drives the clock, the conditions and open-drain data
`timescale 1ns/1ps
module i2c_bus_master (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// ==========================================
	// timing
	// quarter of a 160 ns bus period, changes land on the falling system edge
	task automatic q();
		repeat (4) @(negedge clock_i);
	endtask

	// clock stands high and data released between frames
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	// ==========================================
	// conditions
	// works from idle and as a repeated start with the clock low
	task automatic start();
		sda_oe_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask

	task automatic stop();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b0;
		q();
		q();
	endtask

	// ==========================================
	// byte transfer
	// eight bits then the acknowledge slot; a bit sampled twice reads 0 only if stable low
	task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
		output logic ack_rx);
		logic [8:0] o;
		logic [8:0] r;
		o = {tx, ack_tx};
		for (int i = 8; i >= 0; i--) begin
			sda_oe_o = ~o[i];
			q();
			scl_o = 1'b1;
			q();
			r[i] = sda_i;
			q();
			r[i] = r[i] | sda_i;
			scl_o = 1'b0;
			q();
		end
		rx = r[8:1];
		ack_rx = r[0];
	endtask
endmodule // i2c_bus_master

// file: test/test_serial_eeprom_i2c_slave_front_end.sv
// self-checking bench for the two-wire eeprom slave front end
`timescale 1ns/1ps
module test_serial_eeprom_i2c_slave_front_end;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic scl;
	logic sda;
	logic m_oe;
	logic sda_oe;
	logic dev_sda;
	logic casc;
	logic ready;
	logic valid;
	logic busy;
	logic [2:0] cs;
	logic [7:0] rd_addr;
	logic [7:0] mem [256];
	eeprom_pkg::mem_write_t wr;
	// expected array writes by address, so drain order does not matter
	logic [7:0] exp_w [logic [7:0]];
	int n_fail = 0;
	int check_count = 0;

	always #5 clock_i = ~clock_i;
	// open drain with pull-up
	// the device pulls the wire to its driven value only while enabled
	assign sda = !((sda_oe && !dev_sda) || m_oe);

	i2c_bus_master m (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

	// shorter write cycle keeps the run brief
	eeprom_slave #(.WRITE_CYCLE_CLOCKS(400)) dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
		.sda_oe_o(sda_oe), .chip_select_pin_bit0_i(cs[0]), .chip_select_pin_bit1_i(cs[1]),
		.chip_select_pin_bit2_i(cs[2]), .cascadable_i(casc), .rd_addr_o(rd_addr),
		.rd_data_i(mem[rd_addr]), .mem_wr_valid_o(valid), .mem_wr_ready_i(ready),
		.mem_wr_o(wr), .busy_o(busy));

	// ==========================================
	// checking
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] expv);
		check_count++;
		if (seen !== expv) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, expv, seen);
		end
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// array side stalls at random
	always @(negedge clock_i) ready <= ($urandom % 4) != 0;

	always @(posedge clock_i) begin
		if (resetn_i && valid === 1'b1 && ready) begin
			if (exp_w.exists(wr.addr)) begin
				chk("wr_data", {8'h00, wr.data}, {8'h00, exp_w[wr.addr]});
				exp_w.delete(wr.addr);
			end else
				chk("wr_extra", {8'h00, wr.addr}, 16'hffff);
		end
	end

	// ==========================================
	// bus tasks
	task automatic send(input logic [7:0] b, input logic nack);
		logic [7:0] r;
		logic a;
		m.xfer(b, 1'b1, r, a);
		chk("ack", {15'h0000, a}, {15'h0000, nack});
	endtask

	task automatic wait_idle();
		for (int k = 0; k < 3000 && busy !== 1'b0; k++)
			@(negedge clock_i);
		chk("idle", {15'h0000, busy}, 16'h0000);
		chk("left", 16'(exp_w.size()), 16'h0000);
	endtask

	// control, word address, n data bytes, then only if fin is set stop and poll while busy
	task automatic wr_frame(input logic [7:0] a, input int n, input logic fin);
		logic [7:0] d;
		m.start();
		send({eeprom_pkg::TYPE_CODE, cs, 1'b0}, 1'b0);
		send(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			send(d, 1'b0);
			if (fin && !a[7])
				exp_w[{a[7:4], a[3:0] + 4'(i)}] = d;
		end
		if (fin) begin
			m.stop();
			chk("busy", {15'h0000, busy}, 16'h0001);
			m.start();
			send({eeprom_pkg::TYPE_CODE, cs, 1'b0}, 1'b1);
			m.stop();
			wait_idle();
		end
	endtask

	// ==========================================
	// tests
	initial begin
		logic [7:0] r;
		logic a;
		void'($urandom(5));
		// top pin tied low as on the six-lead part, so matching frames send it as zero
		cs = {1'b0, 2'($urandom)};
		casc = 1'b1;
		ready = 1'b0;
		foreach (mem[i])
			mem[i] = 8'($urandom);
		repeat (8) @(negedge clock_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clock_i);
		wr_frame(8'h12, 1, 1'b1);
		done("byte write");
		wr_frame(8'h25, 18, 1'b1);
		done("page wrap");
		wr_frame(8'h9a, 2, 1'b1);
		done("protected");
		wr_frame(8'h40, 1, 1'b0);
		m.start();
		m.stop();
		repeat (40) @(negedge clock_i);
		chk("no_cycle", {15'h0000, busy}, 16'h0000);
		done("abort");
		send({eeprom_pkg::TYPE_CODE, cs, 1'b0}, 1'b1);
		m.stop();
		done("no start");
		for (int t = 0; t < 16; t++) begin
			m.start();
			send({4'(t), cs, 1'b0}, 4'(t) != eeprom_pkg::TYPE_CODE);
			m.stop();
		end
		for (int c = 0; c < 16; c++) begin
			casc = c[3];
			repeat (4) @(negedge clock_i);
			m.start();
			send({eeprom_pkg::TYPE_CODE, 3'(c), 1'b0}, casc && 3'(c) != cs);
			if (casc && 3'(c) != cs)
				send(8'h00, 1'b1);
			m.stop();
		end
		done("decode");
		m.start();
		send({eeprom_pkg::TYPE_CODE, cs, 1'b0}, 1'b0);
		send(8'hff, 1'b0);
		m.start();
		send({eeprom_pkg::TYPE_CODE, cs, 1'b1}, 1'b0);
		m.xfer(8'hff, 1'b0, r, a);
		chk("rd0", {8'h00, r}, {8'h00, mem[8'hff]});
		m.xfer(8'hff, 1'b1, r, a);
		chk("rd1", {8'h00, r}, {8'h00, mem[8'h00]});
		chk("released", {15'h0000, sda_oe}, 16'h0000);
		m.stop();
		done("read");
		wrap_up();
	end

	// ==========================================
	// watchdog
	// about four times the expected length of the tests
	initial begin
		repeat (60000) @(posedge clock_i);
		n_fail++;
		wrap_up();
	end
endmodule // test_serial_eeprom_i2c_slave_front_end
